// >>> design/mcs_cfg.svh
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH

// ==========================================================
// register byte offsets on the bus
`define MCS_ADR_MODE      4'h0
`define MCS_ADR_SYS       4'h4

// ==========================================================
// operating_mode_status layout
`define MCS_MODE_LSB      8
`define MCS_MODE_FIX      4'h5
`define MCS_MODE_NONE     4'h0

// ==========================================================
// system_settings layout
`define MCS_SYS_SAT       13
`define MCS_SYS_FETCH     11
`define MCS_SYS_EXT       9
`define MCS_SYS_RAM       8
`define MCS_SYS_DTC       1
`define MCS_SYS_ONES      16'hD001

// ==========================================================
// reset values
`define MCS_SAT_RST       1'b0
`define MCS_FETCH_RST     1'b0
`define MCS_EXT_RST       1'b0
`define MCS_RAM_RST       1'b1
`define MCS_DTC_RST       1'b1

`endif

// >>> design/mcs_pkg.sv
package mcs_pkg;

    typedef logic [2:0] mcs_pins_type;
    typedef logic [3:0] mcs_code_type;

    typedef enum logic {
        MCS_BUS_IDLE,
        MCS_BUS_ACK
    } mcs_bus_state_type;

    // ==========================================================
    // pin levels to mode field; reserved pin codes give zero
    function automatic mcs_code_type mode_code(input mcs_pins_type pins);
        case (pins)
            3'h1:    mode_code = 4'hD;
            3'h2:    mode_code = 4'hC;
            3'h4:    mode_code = 4'h2;
            3'h5:    mode_code = 4'h1;
            3'h6:    mode_code = 4'h5;
            3'h7:    mode_code = 4'h4;
            default: mode_code = 4'h0;
        endcase
    endfunction

    // external extended startup modes
    function automatic logic is_extended(input mcs_pins_type pins);
        is_extended = (pins == 3'h4) || (pins == 3'h5) || (pins == 3'h6);
    endfunction

endpackage

// >>> design/mcs_reg_if.sv
`timescale 1ns/1ns
interface mcs_reg_if;
    logic        take_rd;
    logic        take_wr;
    logic        hit_mode;
    logic        hit_sys;
    logic [1:0]  wbe;
    logic [15:0] wdat;
    logic [15:0] mode_rdata;

    modport bus  (output take_rd, take_wr, hit_mode, hit_sys, wbe, wdat);
    modport regs (input take_rd, take_wr, hit_mode, hit_sys, wbe, wdat, output mode_rdata);
    modport mode (input take_rd, hit_mode, output mode_rdata);
endinterface

// >>> design/mcs_wb_slave.sv
`timescale 1ns/1ns
`include "mcs_cfg.svh"
module mcs_wb_slave (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic             ack_o,
    mcs_reg_if.bus           rif
);
    mcs_pkg::mcs_bus_state_type state_q;
    mcs_pkg::mcs_bus_state_type state_d;
    logic                       req;

    // ==========================================================
    // one access per request, ack one cycle later, then a gap
    assign req          = cyc_i & stb_i & (state_q == mcs_pkg::MCS_BUS_IDLE);
    assign rif.take_rd  = req & ~we_i;
    assign rif.take_wr  = req & we_i;
    assign rif.hit_mode = (adr_i == `MCS_ADR_MODE);
    assign rif.hit_sys  = (adr_i == `MCS_ADR_SYS);
    assign rif.wbe      = sel_i[1:0];
    assign rif.wdat     = dat_i[15:0];
    assign ack_o        = (state_q == mcs_pkg::MCS_BUS_ACK);

    always_comb begin
        case (state_q)
            mcs_pkg::MCS_BUS_IDLE: state_d = req ? mcs_pkg::MCS_BUS_ACK : mcs_pkg::MCS_BUS_IDLE;
            mcs_pkg::MCS_BUS_ACK:  state_d = mcs_pkg::MCS_BUS_IDLE;
            default:               state_d = mcs_pkg::MCS_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= mcs_pkg::MCS_BUS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end
endmodule // mcs_wb_slave

// >>> design/mcs_mode_latch.sv
`timescale 1ns/1ns
`include "mcs_cfg.svh"
module mcs_mode_latch (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [2:0]  mode_pins_i,
    output logic             latched_o,
    mcs_reg_if.mode          rif
);
    logic                  latched_q;
    mcs_pkg::mcs_code_type code_q;
    mcs_pkg::mcs_code_type live_code;
    mcs_pkg::mcs_code_type field;
    logic                  grab;

    // ==========================================================
    // live until the first read, then frozen until reset
    assign live_code = mcs_pkg::mode_code(mode_pins_i);
    assign grab      = rif.take_rd & rif.hit_mode & ~latched_q;
    assign field     = latched_q ? code_q : live_code;
    assign latched_o = latched_q;
    // low nibble mirrors the pin-derived field
    assign rif.mode_rdata = {`MCS_MODE_FIX, field, `MCS_MODE_FIX, field};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_q <= 1'b0;
            code_q    <= `MCS_MODE_NONE;
        end else if (grab) begin
            latched_q <= 1'b1;
            code_q    <= live_code;
        end
    end
endmodule // mcs_mode_latch

// >>> design/mcs_top.sv
// How it works
// - a read of operating_mode_status freezes the current mode pin levels into its mode field.
// - reset drops that frozen value so the next read samples the pins again.
// - the mode field sits in bits 11:8 and encodes pins 001,010,100,101,110,111 as 1101,1100,0010,0001,0101,0100.
// - operating_mode_status is read-only, bits 15:12 and 7:4 always read 0101.
// - bits 3:0 of operating_mode_status follow the pin-derived mode value.
// - system_settings bits 15 and 14 read 1 and software writes 1 there.
// - system_settings bit 12 reads 1 and software writes 1 there.
// - bit 13 resets to 0 and turns on saturating multiply_accumulate when 1.
// - bit 11 resets to 0; 0 picks 32-bit prefetch units and 1 picks 16-bit units.
// - the reset value of the external bus enable depends on the startup pins.
// - bits 9, 8 and 1 are read-write, bit 8 and bit 1 resetting to 1.
// - in external extended modes bit 9 is stuck at 1, in single-chip mode it resets to 0 and is writable.
// - bit 8 at 0 disables the on-chip RAM and at 1 enables it, and reset restores it.
// - bit 1 at 0 gives full-address transfer_controller mode, at 1 short-address mode.
// - bits 10 and 7:2 read 0 and bit 0 reads 1, and software writes those values back.
`timescale 1ns/1ns
`include "mcs_cfg.svh"
module mcs_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic [2:0]  mode_pins_i,
    output logic             saturation_select_o,
    output logic             prefetch_width_select_o,
    output logic             external_bus_enable_o,
    output logic             onchip_ram_enable_o,
    output logic             transfer_ctrl_address_mode_o
);
    mcs_reg_if rif ();

    mcs_pkg::mcs_pins_type boot_pins_q;
    logic                  sat_q;
    logic                  sat_d;
    logic                  fetch_q;
    logic                  fetch_d;
    logic                  ext_q;
    logic                  ext_d;
    logic                  ram_q;
    logic                  ram_d;
    logic                  dtc_q;
    logic                  dtc_d;
    logic [31:0]           dat_q;
    logic [31:0]           dat_d;
    logic                  ext_fixed;
    logic                  ext_bit;
    logic                  wr_hi;
    logic                  wr_lo;
    logic [15:0]           sys_value;
    logic                  mode_latched;

    // ==========================================================
    // bus slave and mode-status latch
    mcs_wb_slave u_slave (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cyc_i (cyc_i),
        .stb_i (stb_i),
        .we_i  (we_i),
        .adr_i (adr_i),
        .sel_i (sel_i),
        .dat_i (dat_i),
        .ack_o (ack_o),
        .rif   (rif.bus)
    );

    mcs_mode_latch u_mode (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .mode_pins_i (mode_pins_i),
        .latched_o   (mode_latched),
        .rif         (rif.mode)
    );

    // ==========================================================
    // system_settings decode
    // writes to operating_mode_status have no path here, so they vanish
    assign wr_hi     = rif.take_wr & rif.hit_sys & rif.wbe[1];
    assign wr_lo     = rif.take_wr & rif.hit_sys & rif.wbe[0];
    // startup pins are caught while reset is held, so bit 9 never sees a mid-run pin change
    assign ext_fixed = mcs_pkg::is_extended(boot_pins_q);
    assign ext_bit   = ext_fixed | ext_q;

    assign sat_d   = wr_hi ? rif.wdat[`MCS_SYS_SAT]   : sat_q;
    assign fetch_d = wr_hi ? rif.wdat[`MCS_SYS_FETCH] : fetch_q;
    assign ext_d   = wr_hi ? rif.wdat[`MCS_SYS_EXT]   : ext_q;
    assign ram_d   = wr_hi ? rif.wdat[`MCS_SYS_RAM]   : ram_q;
    assign dtc_d   = wr_lo ? rif.wdat[`MCS_SYS_DTC]   : dtc_q;

    // fixed ones and zeros are not stored, so a careless write cannot upset them
    always_comb begin
        sys_value                 = `MCS_SYS_ONES;
        sys_value[`MCS_SYS_SAT]   = sat_q;
        sys_value[`MCS_SYS_FETCH] = fetch_q;
        sys_value[`MCS_SYS_EXT]   = ext_bit;
        sys_value[`MCS_SYS_RAM]   = ram_q;
        sys_value[`MCS_SYS_DTC]   = dtc_q;
    end

    // unmapped offsets read as zero and still get an ack
    assign dat_d = ~rif.take_rd ? dat_q :
                   rif.hit_mode ? {16'h0000, rif.mode_rdata} :
                   rif.hit_sys  ? {16'h0000, sys_value} : 32'h00000000;

    // ==========================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_pins_q <= mode_pins_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sat_q   <= `MCS_SAT_RST;
            fetch_q <= `MCS_FETCH_RST;
            ext_q   <= `MCS_EXT_RST;
            ram_q   <= `MCS_RAM_RST;
            dtc_q   <= `MCS_DTC_RST;
            dat_q   <= 32'h00000000;
        end else begin
            sat_q   <= sat_d;
            fetch_q <= fetch_d;
            ext_q   <= ext_d;
            ram_q   <= ram_d;
            dtc_q   <= dtc_d;
            dat_q   <= dat_d;
        end
    end

    // ==========================================================
    // outputs
    assign dat_o                        = dat_q;
    assign saturation_select_o          = sat_q;
    assign prefetch_width_select_o      = fetch_q;
    assign external_bus_enable_o        = ext_bit;
    assign onchip_ram_enable_o          = ram_q;
    assign transfer_ctrl_address_mode_o = dtc_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic       seen_q;
    logic [3:0] field_now;
    assign field_now = rif.mode_rdata[11:8];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_q <= 1'b0;
        end else if (rif.take_rd && rif.hit_mode) begin
            seen_q <= 1'b1;
        end
    end

    chk_mode_frozen_hold: assert property (seen_q |-> $stable(field_now))
        else $error("mode field moved after a read");

    chk_mode_grab_value: assert property (
        (rif.take_rd && rif.hit_mode && !seen_q) |=>
            field_now == mcs_pkg::mode_code($past(mode_pins_i)))
        else $error("mode field not taken from pins at read");

    chk_mode_live_track: assert property (
        !seen_q |-> field_now == mcs_pkg::mode_code(mode_pins_i))
        else $error("mode field not tracking pins before first read");

    chk_mode_reset_release: assert property ($fell(rst_i) |-> !mode_latched)
        else $error("mode latch survived reset");

    chk_mode_fixed_bits: assert property (
        rif.mode_rdata[15:12] == 4'h5 && rif.mode_rdata[7:4] == 4'h5 &&
        rif.mode_rdata[3:0] == field_now)
        else $error("mode status fixed bits wrong");

    chk_mode_read_data: assert property (
        (rif.take_rd && rif.hit_mode) |=> ack_o && dat_o == {16'h0000, $past(rif.mode_rdata)})
        else $error("mode status read data wrong");

    chk_sys_fixed_bits: assert property (
        sys_value[15:14] == 2'b11 && sys_value[12] && !sys_value[10] &&
        sys_value[7:2] == 6'h00 && sys_value[0])
        else $error("system settings fixed bits wrong");

    chk_sat_fetch_write: assert property (
        wr_hi |=> saturation_select_o == $past(rif.wdat[13]) &&
                  prefetch_width_select_o == $past(rif.wdat[11]))
        else $error("saturation or prefetch bit missed a write");

    chk_ext_fixed_high: assert property (ext_fixed |-> external_bus_enable_o)
        else $error("external bus enable dropped in extended mode");

    chk_ext_single_write: assert property (
        (!ext_fixed && wr_hi) |=> external_bus_enable_o == $past(rif.wdat[9]))
        else $error("external bus enable not writable in single-chip mode");

    chk_reset_values: assert property (
        $fell(rst_i) |-> !saturation_select_o && !prefetch_width_select_o &&
            onchip_ram_enable_o && transfer_ctrl_address_mode_o &&
            external_bus_enable_o == ext_fixed)
        else $error("system settings reset values wrong");

    chk_ram_dtc_write: assert property (
        (wr_hi && wr_lo) |=> onchip_ram_enable_o == $past(rif.wdat[8]) &&
            transfer_ctrl_address_mode_o == $past(rif.wdat[1]))
        else $error("ram or transfer mode bit missed a write");

    // ==========================================================
    // hold, decode and read-back checks
    // a stored bit may move only in the cycle after its own byte lane is written
    chk_sat_hold: assert property (
        !wr_hi |=> $stable(saturation_select_o))
        else $error("saturation bit moved without a write");

    chk_fetch_hold: assert property (
        !wr_hi |=> $stable(prefetch_width_select_o))
        else $error("prefetch bit moved without a write");

    chk_ram_hold: assert property (
        !wr_hi |=> $stable(onchip_ram_enable_o))
        else $error("ram enable moved without a write");

    chk_ext_hold: assert property (
        !wr_hi |=> $stable(external_bus_enable_o))
        else $error("external bus enable moved without a write");

    chk_dtc_hold: assert property (
        !wr_lo |=> $stable(transfer_ctrl_address_mode_o))
        else $error("transfer mode bit moved without a write");

    chk_ram_write: assert property (
        wr_hi |=> onchip_ram_enable_o == $past(rif.wdat[8]))
        else $error("ram enable missed a write");

    chk_dtc_low_write: assert property (
        (wr_lo && !wr_hi) |=> transfer_ctrl_address_mode_o == $past(rif.wdat[1]))
        else $error("transfer mode bit missed a low byte write");

    chk_mode_write_ignored: assert property (
        (rif.take_wr && rif.hit_mode) |=> $stable(mode_latched))
        else $error("write to mode status touched the latch");

    chk_mode_write_isolated: assert property (
        (rif.take_wr && rif.hit_mode) |=> $stable(sys_value))
        else $error("write to mode status reached system settings");

    chk_latch_on_read: assert property (
        (rif.take_rd && rif.hit_mode) |=> mode_latched)
        else $error("mode latch not set by a read");

    chk_latch_stays: assert property (
        mode_latched |=> mode_latched)
        else $error("mode latch dropped without reset");

    // the table is spelled out here so a slip in the shared decode function still shows
    chk_mode_code_table: assert property (
        !seen_q |-> (mode_pins_i != 3'h1 || field_now == 4'hD) &&
            (mode_pins_i != 3'h2 || field_now == 4'hC) &&
            (mode_pins_i != 3'h4 || field_now == 4'h2) &&
            (mode_pins_i != 3'h5 || field_now == 4'h1) &&
            (mode_pins_i != 3'h6 || field_now == 4'h5) &&
            (mode_pins_i != 3'h7 || field_now == 4'h4))
        else $error("mode field encoding wrong");

    chk_sys_read_data: assert property (
        (rif.take_rd && rif.hit_sys) |=> ack_o && dat_o == {16'h0000, $past(sys_value)})
        else $error("system settings read data wrong");

    chk_ext_reset_single: assert property (
        ($fell(rst_i) && !ext_fixed) |-> !external_bus_enable_o)
        else $error("external bus enable not cleared by reset in single-chip mode");

    chk_ext_pins_decode: assert property (
        ext_fixed == (boot_pins_q[2] && boot_pins_q != 3'h7))
        else $error("startup pins decoded to wrong external bus mode");

    chk_ack_after_req: assert property (
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("request not answered in the next cycle");

    chk_dat_hold: assert property (
        !rif.take_rd |=> $stable(dat_o))
        else $error("read data moved without a read");

    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    cov_mode_read: cover property (rif.take_rd && rif.hit_mode ##1 ack_o);
    cov_sys_write: cover property (wr_hi && wr_lo ##1 ack_o);
    cov_ext_set_single: cover property (!ext_fixed && wr_hi && rif.wdat[9]);
    cov_unmapped: cover property (rif.take_rd && !rif.hit_mode && !rif.hit_sys);
    cov_dtc_low_write: cover property (wr_lo && !wr_hi);
endmodule // mcs_top

// >>> sim/mcs_pin_strap_model.sv
`timescale 1ns/1ns
// ==========================================================
// board strapping of the three mode pins; the strap is moved
// only by the bench, and reaches the pins one edge later
module mcs_pin_strap_model (
    input  wire logic       clk_i,
    input  wire logic [2:0] strap_i,
    output logic      [2:0] mode_pins_o
);
    logic [2:0] pins_q = 3'h7;

    always @(posedge clk_i) begin
        pins_q <= strap_i;
    end

    assign mode_pins_o = pins_q;
endmodule // mcs_pin_strap_model

// >>> sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic        clk_i;
    logic        rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [3:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [2:0]  strap;
    logic [2:0]  mode_pins;
    logic [4:0]  outs;
    logic [31:0] rd;
    int          fails;
    int          n_tests;

    mcs_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mode_pins_i(mode_pins),
        .saturation_select_o(outs[4]), .prefetch_width_select_o(outs[3]), .external_bus_enable_o(outs[2]),
        .onchip_ram_enable_o(outs[1]), .transfer_ctrl_address_mode_o(outs[0]));

    mcs_pin_strap_model pins (.clk_i(clk_i), .strap_i(strap), .mode_pins_o(mode_pins));

    // ==========================================================
    // helpers
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // classic single cycle; the slave answers when it likes, the bound only cuts a hang
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [15:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {16'h0000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 20) begin
            fails++;
            tally_and_finish();
        end else begin
            @(posedge clk_i);
        end
    endtask

    task automatic do_reset(input logic [2:0] p);
        strap <= p;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset_values();
        wb(1'b0, 4'h4, 4'hF, 16'h0000);
        check(rd, 32'h0000D103);
        check({27'h0, outs}, 32'h03);
    endtask

    task automatic t_live_then_latch();
        strap <= 3'h1;
        repeat (2) @(posedge clk_i);
        wb(1'b0, 4'h0, 4'hF, 16'h0000);
        check(rd, 32'h00005D5D);
        strap <= 3'h7;
        repeat (2) @(posedge clk_i);
        wb(1'b1, 4'h0, 4'hF, 16'hFFFF);
        wb(1'b0, 4'h0, 4'hF, 16'h0000);
        check(rd, 32'h00005D5D);
        check(rd, 32'h00005D5D);
    endtask

    task automatic t_modes();
        logic [2:0] pv [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
        logic [3:0] cv [6] = '{4'hD, 4'hC, 4'h2, 4'h1, 4'h5, 4'h4};
        logic       ev [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++) begin
            do_reset(pv[i]);
            wb(1'b0, 4'h0, 4'hF, 16'h0000);
            check(rd, {16'h0000, 4'h5, cv[i], 4'h5, cv[i]});
            check(rd, {16'h0000, 4'h5, cv[i], 4'h5, cv[i]});
            wb(1'b0, 4'h4, 4'hF, 16'h0000);
            check(rd, 32'h0000D103 | {22'h0, ev[i], 9'h000});
            check({31'h0, outs[2]}, {31'h0, ev[i]});
        end
    endtask

    task automatic t_sys_write();
        // single-chip start so that the external bus bit is writable
        do_reset(3'h7);
        wb(1'b1, 4'h4, 4'hF, 16'hFB03);
        wb(1'b0, 4'h4, 4'hF, 16'h0000);
        check(rd, 32'h0000FB03);
        check({27'h0, outs}, 32'h1F);
        wb(1'b1, 4'h4, 4'h3, 16'hD001);
        wb(1'b0, 4'h4, 4'hF, 16'h0000);
        check(rd, 32'h0000D001);
        check(rd, 32'h0000D001);
        check(rd, 32'h0000D001);
        check({27'h0, outs}, 32'h00);
        wb(1'b1, 4'h4, 4'h1, 16'hD003);
        wb(1'b0, 4'h4, 4'hF, 16'h0000);
        check(rd, 32'h0000D003);
        wb(1'b1, 4'h8, 4'hF, 16'hFFFF);
        wb(1'b0, 4'h8, 4'hF, 16'h0000);
        check(rd, 32'h00000000);
    endtask

    task automatic t_ext_locked();
        do_reset(3'h4);
        wb(1'b1, 4'h4, 4'h3, 16'hD001);
        wb(1'b0, 4'h4, 4'hF, 16'h0000);
        check(rd, 32'h0000D201);
        check({27'h0, outs}, 32'h04);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        fails = 0;
        n_tests = 0;
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 4'h0;
        sel_i = 4'h0;
        dat_i = 32'h00000000;
        strap = 3'h7;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values();
        t_live_then_latch();
        t_modes();
        t_sys_write();
        t_ext_locked();
        tally_and_finish();
    end
endmodule // testbench
